//--- src/rfc_map.svh
// Register offsets, field positions and reset values of the converter control
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH
`define RFC_ADR_CLK    16'h5067
`define RFC_ADR_CTL    16'h53a0
`define RFC_ADR_TRG    16'h53a2
`define RFC_ADR_MCL    16'h53a4
`define RFC_ADR_MCH    16'h53a6
`define RFC_ADR_TCL    16'h53a8
`define RFC_ADR_TCH    16'h53aa
`define RFC_ADR_IMSK   16'h53ac
`define RFC_ADR_IFLG   16'h53ae
`define RFC_DIV_LSB    4
`define RFC_SRC_LSB    2
`define RFC_GATE_BIT   0
`define RFC_FREE_BIT   7
`define RFC_EVT_BIT    6
`define RFC_STYPE_LSB  4
`define RFC_CH_BIT     1
`define RFC_EN_BIT     0
`define OSCILLATION_TRIGGER_B      2
`define OSCILLATION_TRIGGER_A      1
`define OSCILLATION_TRIGGER_REF    0
`define RFC_IRQ_TOV    4
`define RFC_IRQ_MOV    3
`define RFC_IRQ_B      2
`define RFC_IRQ_A      1
`define RFC_IRQ_REF    0
`define RFC_DIV_RST    2'h0
`define RFC_SRC_RST    2'h1
`define RFC_STYPE_RST  2'h0
`define RFC_CNT_RST    24'h00_0000
`define RFC_IRQ_RST    5'h00
`endif

//--- src/rfc_pkg.sv
// Types shared by the converter control modules
package rfc_pkg;
  typedef enum logic [1:0] {
    RFC_IDLE  = 2'h0,
    RFC_REF   = 2'h1,
    RFC_SEN_A = 2'h3,
    RFC_SEN_B = 2'h2
  } rfc_state_t;
  typedef enum logic [1:0] {
    RFC_SRC_INT  = 2'h0,
    RFC_SRC_LOW  = 2'h1,
    RFC_SRC_HIGH = 2'h2,
    RFC_SRC_RSV  = 2'h3
  } rfc_src_t;
endpackage

//--- src/rfc_count_clock_divider_sel.sv
// Counting clock source select and divider, producing a one-cycle tick
`timescale 1ns/1ps
module rfc_count_clock_divider_sel (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       int_osc_tick,
  input  wire logic       low_osc_tick,
  input  wire logic       high_osc_tick,
  input  wire logic [1:0] source_sel,
  input  wire logic [1:0] divider_sel,
  input  wire logic       gate,
  output logic            tick
);
  logic [2:0] cnt;
  logic [2:0] mask;
  logic       src_tick;
  logic       bypass;

  always_comb begin
    src_tick = 1'b0;
    bypass   = 1'b0;
    unique case (rfc_pkg::rfc_src_t'(source_sel))
      rfc_pkg::RFC_SRC_INT:  src_tick = int_osc_tick;
      rfc_pkg::RFC_SRC_LOW: begin
        src_tick = low_osc_tick;
        bypass   = 1'b1;
      end
      rfc_pkg::RFC_SRC_HIGH: src_tick = high_osc_tick;
      rfc_pkg::RFC_SRC_RSV:  src_tick = 1'b0;
    endcase
  end

  // Code n divides by 2**n: mask selects how many low count bits must be set
  always_comb begin
    unique case (divider_sel)
      2'h3: mask = 3'h7;
      2'h2: mask = 3'h3;
      2'h1: mask = 3'h1;
      2'h0: mask = 3'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !gate) begin
      cnt <= 3'h0;
    end else if (src_tick && !bypass) begin
      cnt <= 3'(cnt + 3'h1);
    end
  end

  assign tick = gate & src_tick & (bypass | ((cnt & mask) == mask));

  AST_DIV8_SPACING: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tick && divider_sel == 2'h3 && source_sel == 2'h0) |-> (cnt == 3'h7))
    else $error("divide by 8 tick at wrong phase");
  AST_GATE_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!gate || source_sel == 2'h3) |-> !tick)
    else $error("count tick while gated or reserved source");
endmodule

//--- src/rfc_cnt24.sv
// 24-bit up/down counter with 16+8 bit software preset
`timescale 1ns/1ps
module rfc_cnt24 (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        load_lo,
  input  wire logic        load_hi,
  input  wire logic [15:0] load_data,
  input  wire logic        inc,
  input  wire logic        dec,
  output logic      [23:0] q,
  output logic             wrap
);
  `include "rfc_map.svh"

  // A software preset beats a count arriving in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= `RFC_CNT_RST;
    end else if (load_lo) begin
      q[15:0] <= load_data;
    end else if (load_hi) begin
      q[23:16] <= load_data[7:0];
    end else if (inc) begin
      q <= 24'(q + 24'h00_0001);
    end else if (dec) begin
      q <= 24'(q - 24'h00_0001);
    end
  end

  assign wrap = !load_lo && !load_hi && ((inc && (&q)) || (!inc && dec && !(|q)));
endmodule

//--- src/rfc_top.sv
// Converter control: registers, oscillation sequencer, counters and interrupts
// Operation
// - Counting clock divided by 8,4,2,1 for codes 3..0, internal or fast source only.
// - Source field: 0 internal, 1 slow, 2 fast, 3 reserved; resets slow; gated.
// - Control bit 7 enables continuous oscillation, resets off.
// - Control bit 6 enables event counting mode, resets off.
// - Sensor type field: 0 DC resistive, 1 AC resistive, 2 capacitive.
// - Control bit 1 selects channel 1 when set, channel 0 when clear.
// - Trigger bits 2 and 1 start/stop sensor B/A and read back running.
// - Trigger bit 0 starts/stops reference oscillation and reads back running.
// - Time base counter low 16 bits are readable and presettable.
// - Time base counter upper byte in low byte, upper byte reads zero.
// - Time base overflow reaches interrupt only when mask bit 4 set.
// - Measurement overflow reaches interrupt only when mask bit 3 set.
// - Reference completion reaches interrupt only when mask bit 0 set.
// - Sensor B and A completion reach interrupt via mask bits 2 and 1.
// - Overflows set flags 4 and 3; writing one clears, zero keeps.
// - Completions set flags 2,1,0; writing one clears; reset zero.
`timescale 1ns/1ps
module rfc_top (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        int_osc_tick,
  input  wire logic        low_osc_tick,
  input  wire logic        high_osc_tick,
  input  wire logic        osc_edge,
  output logic             ref_osc_run,
  output logic             sen_a_osc_run,
  output logic             sen_b_osc_run,
  output logic             free_running_osc_en,
  output logic             event_count_mode_en,
  output logic      [1:0]  sensor_type_sel,
  output logic             channel_sel,
  output logic             irq
);
  `include "rfc_map.svh"

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]  count_clock_divider_sel;
  logic [1:0]  count_clock_source_sel;
  logic        count_clock_gate;
  logic        conv_en;
  logic [4:0]  irq_mask;
  logic [4:0]  irq_flags;
  logic [4:0]  irq_set;
  logic [4:0]  irq_clr;
  logic [23:0] measurement_count;
  logic [23:0] time_base_count;
  logic        mc_wrap;
  logic        tc_wrap;
  logic        mc_inc;
  logic        tc_inc;
  logic        tc_dec;
  logic        clk_tick;
  logic        running;
  logic        sensing;
  logic        stop_req;
  logic        ref_done;
  logic        sen_done;
  logic        mov_evt;
  logic        tov_evt;
  logic        err_stop;
  logic [15:0] next_rdata;
  logic        wr_clk;
  logic        wr_ctl;
  logic        wr_trg;
  rfc_pkg::rfc_state_t state;
  rfc_pkg::rfc_state_t next_state;

  assign wr_clk = reg_wr && reg_addr == `RFC_ADR_CLK;
  assign wr_ctl = reg_wr && reg_addr == `RFC_ADR_CTL;
  assign wr_trg = reg_wr && reg_addr == `RFC_ADR_TRG;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock control register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_clock_divider_sel <= `RFC_DIV_RST;
      count_clock_source_sel  <= `RFC_SRC_RST;
      count_clock_gate        <= 1'b0;
    end else if (wr_clk) begin
      count_clock_divider_sel <= reg_wdata[`RFC_DIV_LSB +: 2];
      count_clock_source_sel  <= reg_wdata[`RFC_SRC_LSB +: 2];
      count_clock_gate        <= reg_wdata[`RFC_GATE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      free_running_osc_en <= 1'b0;
      event_count_mode_en <= 1'b0;
      sensor_type_sel     <= `RFC_STYPE_RST;
      channel_sel         <= 1'b0;
      conv_en             <= 1'b0;
    end else if (wr_ctl) begin
      free_running_osc_en <= reg_wdata[`RFC_FREE_BIT];
      event_count_mode_en <= reg_wdata[`RFC_EVT_BIT];
      sensor_type_sel     <= reg_wdata[`RFC_STYPE_LSB +: 2];
      channel_sel         <= reg_wdata[`RFC_CH_BIT];
      conv_en             <= reg_wdata[`RFC_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counting clock
  // The converter enable also gates the tick, so nothing counts while disabled
  rfc_count_clock_divider_sel u_count_clock_divider_sel (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .int_osc_tick  (int_osc_tick),
    .low_osc_tick  (low_osc_tick),
    .high_osc_tick (high_osc_tick),
    .source_sel    (count_clock_source_sel),
    .divider_sel   (count_clock_divider_sel),
    .gate          (count_clock_gate && conv_en),
    .tick          (clk_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillation sequencer
  // Only one oscillation runs at a time; a write naming several starts only one:
  // the reference if named, else sensor A, else sensor B.
  assign running = state != rfc_pkg::RFC_IDLE;
  assign sensing = state == rfc_pkg::RFC_SEN_A || state == rfc_pkg::RFC_SEN_B;

  always_comb begin
    stop_req = 1'b0;
    unique case (state)
      rfc_pkg::RFC_IDLE:  stop_req = 1'b0;
      rfc_pkg::RFC_REF:   stop_req = wr_trg && !reg_wdata[`OSCILLATION_TRIGGER_REF];
      rfc_pkg::RFC_SEN_A: stop_req = wr_trg && !reg_wdata[`OSCILLATION_TRIGGER_A];
      rfc_pkg::RFC_SEN_B: stop_req = wr_trg && !reg_wdata[`OSCILLATION_TRIGGER_B];
    endcase
  end

  // Reference ends when the measurement count rolls over; a sensor run ends
  // when the time base count reaches zero. Continuous mode never ends by itself.
  assign ref_done = state == rfc_pkg::RFC_REF && mc_wrap && !free_running_osc_en;
  assign sen_done = sensing && tc_dec && time_base_count == 24'h00_0001
                    && !free_running_osc_en;
  assign tov_evt  = tc_wrap && running;
  assign mov_evt  = mc_wrap && sensing;
  assign err_stop = (tov_evt || mov_evt) && !free_running_osc_en;

  always_comb begin
    next_state = state;
    unique case (state)
      rfc_pkg::RFC_IDLE: begin
        if (wr_trg && conv_en) begin
          if (reg_wdata[`OSCILLATION_TRIGGER_REF]) begin
            next_state = rfc_pkg::RFC_REF;
          end else if (reg_wdata[`OSCILLATION_TRIGGER_A]) begin
            next_state = rfc_pkg::RFC_SEN_A;
          end else if (reg_wdata[`OSCILLATION_TRIGGER_B]) begin
            next_state = rfc_pkg::RFC_SEN_B;
          end
        end
      end
      rfc_pkg::RFC_REF,
      rfc_pkg::RFC_SEN_A,
      rfc_pkg::RFC_SEN_B: begin
        if (!conv_en || stop_req || ref_done || sen_done || err_stop) begin
          next_state = rfc_pkg::RFC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= rfc_pkg::RFC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign ref_osc_run   = state == rfc_pkg::RFC_REF;
  assign sen_a_osc_run = state == rfc_pkg::RFC_SEN_A;
  assign sen_b_osc_run = state == rfc_pkg::RFC_SEN_B;

  ////////////////////////////////////////////////////////////////////////////////
  // Counters
  // In event mode the time base stands still and only events are counted
  assign mc_inc = running && conv_en && osc_edge;
  assign tc_inc = ref_osc_run && clk_tick && !event_count_mode_en;
  assign tc_dec = sensing && clk_tick && !event_count_mode_en;

  rfc_cnt24 u_measure (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .load_lo   (reg_wr && reg_addr == `RFC_ADR_MCL),
    .load_hi   (reg_wr && reg_addr == `RFC_ADR_MCH),
    .load_data (reg_wdata),
    .inc       (mc_inc),
    .dec       (1'b0),
    .q         (measurement_count),
    .wrap      (mc_wrap)
  );

  rfc_cnt24 u_time_base (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .load_lo   (reg_wr && reg_addr == `RFC_ADR_TCL),
    .load_hi   (reg_wr && reg_addr == `RFC_ADR_TCH),
    .load_data (reg_wdata),
    .inc       (tc_inc),
    .dec       (tc_dec),
    .q         (time_base_count),
    .wrap      (tc_wrap)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt mask, flags and output
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_mask <= `RFC_IRQ_RST;
    end else if (reg_wr && reg_addr == `RFC_ADR_IMSK) begin
      irq_mask <= reg_wdata[4:0];
    end
  end

  always_comb begin
    irq_set               = 5'h00;
    irq_set[`RFC_IRQ_TOV] = tov_evt;
    irq_set[`RFC_IRQ_MOV] = mov_evt;
    irq_set[`RFC_IRQ_B]   = sen_done && sen_b_osc_run;
    irq_set[`RFC_IRQ_A]   = sen_done && sen_a_osc_run;
    irq_set[`RFC_IRQ_REF] = ref_done;
  end

  assign irq_clr = (reg_wr && reg_addr == `RFC_ADR_IFLG) ? reg_wdata[4:0] : 5'h00;

  // An event in the clearing cycle survives: set is applied after clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_flags <= `RFC_IRQ_RST;
    end else begin
      irq_flags <= (irq_flags & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_flags & irq_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `RFC_ADR_CLK: begin
          next_rdata[`RFC_DIV_LSB +: 2] = count_clock_divider_sel;
          next_rdata[`RFC_SRC_LSB +: 2] = count_clock_source_sel;
          next_rdata[`RFC_GATE_BIT]     = count_clock_gate;
        end
        `RFC_ADR_CTL: begin
          next_rdata[`RFC_FREE_BIT]       = free_running_osc_en;
          next_rdata[`RFC_EVT_BIT]        = event_count_mode_en;
          next_rdata[`RFC_STYPE_LSB +: 2] = sensor_type_sel;
          next_rdata[`RFC_CH_BIT]         = channel_sel;
          next_rdata[`RFC_EN_BIT]         = conv_en;
        end
        `RFC_ADR_TRG: begin
          next_rdata[`OSCILLATION_TRIGGER_B]   = sen_b_osc_run;
          next_rdata[`OSCILLATION_TRIGGER_A]   = sen_a_osc_run;
          next_rdata[`OSCILLATION_TRIGGER_REF] = ref_osc_run;
        end
        `RFC_ADR_MCL:  next_rdata       = measurement_count[15:0];
        `RFC_ADR_MCH:  next_rdata[7:0]  = measurement_count[23:16];
        `RFC_ADR_TCL:  next_rdata       = time_base_count[15:0];
        `RFC_ADR_TCH:  next_rdata[7:0]  = time_base_count[23:16];
        `RFC_ADR_IMSK: next_rdata[4:0]  = irq_mask;
        `RFC_ADR_IFLG: next_rdata[4:0]  = irq_flags;
        default:       next_rdata       = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_TRG_READBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `RFC_ADR_TRG) |=>
      (reg_rdata == {13'h0000, $past(sen_b_osc_run), $past(sen_a_osc_run),
                     $past(ref_osc_run)}))
    else $error("trigger read back differs from running state");
  AST_REF_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!running && conv_en && wr_trg && reg_wdata[`OSCILLATION_TRIGGER_REF]) |=> ref_osc_run)
    else $error("reference oscillation did not start");
  AST_STOP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sen_a_osc_run && wr_trg && !reg_wdata[`OSCILLATION_TRIGGER_A]) |=> !sen_a_osc_run)
    else $error("sensor A did not stop on zero write");
  AST_NO_COUNT_DIS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!conv_en && !reg_wr) |=> $stable(measurement_count) && $stable(time_base_count))
    else $error("counter moved while converter disabled");
  AST_MOV_FLAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mov_evt |=> irq_flags[`RFC_IRQ_MOV])
    else $error("measurement overflow flag not set");
  AST_REF_DONE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ref_done |=> irq_flags[`RFC_IRQ_REF] && !ref_osc_run)
    else $error("reference completion not flagged");
  AST_TOV_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tov_evt && irq_mask[`RFC_IRQ_TOV] && !(reg_wr && reg_addr == `RFC_ADR_IMSK))
      |=> irq)
    else $error("enabled time base overflow gave no interrupt");
  AST_MASKED_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((irq_flags & irq_mask) == 5'h00) |-> !irq)
    else $error("interrupt raised with all flags masked");
  AST_TCH_RSV: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `RFC_ADR_TCH) |=> (reg_rdata[15:8] == 8'h00))
    else $error("reserved time base bits read non-zero");
  AST_W1C: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (irq_clr[`RFC_IRQ_A] && !irq_set[`RFC_IRQ_A]) |=> !irq_flags[`RFC_IRQ_A])
    else $error("sensor A flag not cleared by one write");
  AST_CONT_RUN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ref_osc_run && free_running_osc_en && conv_en && !reg_wr) |=> ref_osc_run)
    else $error("continuous reference run ended by itself");
  AST_EVT_TC_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (event_count_mode_en && !reg_wr) |=> $stable(time_base_count))
    else $error("time base moved in event counting mode");
  AST_CH_SEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_ctl |=> (channel_sel == $past(reg_wdata[`RFC_CH_BIT])))
    else $error("channel select did not follow control write");
  AST_SEN_B_DONE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sen_done && sen_b_osc_run) |=> (irq_flags[`RFC_IRQ_B] && !running))
    else $error("sensor B completion not flagged");
  AST_CTL_RSV: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `RFC_ADR_CTL) |=> (reg_rdata[15:8] == 8'h00))
    else $error("reserved control bits read non-zero");
endmodule

//--- verification/rfc_osc_model.sv
// Stand-in for the sensor oscillator circuit and the three count clock sources
`timescale 1ns/1ps
module rfc_osc_model #(
  parameter int EDGE_DIV = 3
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic run_any,
  output logic      int_osc_tick,
  output logic      low_osc_tick,
  output logic      high_osc_tick,
  output logic      osc_edge
);
  logic [7:0] div_cnt;
  logic [7:0] edge_cnt;

  initial begin
    div_cnt = 8'h00;
    edge_cnt = 8'h00;
    int_osc_tick = 1'b0;
    low_osc_tick = 1'b0;
    high_osc_tick = 1'b0;
    osc_edge = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sources run free: internal every 2nd cycle, slow every 8th, fast every cycle
  always @(posedge ref_clk) begin
    div_cnt <= div_cnt + 8'h01;
    int_osc_tick <= div_cnt[0];
    low_osc_tick <= (div_cnt[2:0] == 3'h7);
    high_osc_tick <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The sensing element only swings while a run holds it, so no stray edges
  always @(posedge ref_clk) begin
    if (sys_rst || !run_any) begin
      edge_cnt <= 8'h00;
      osc_edge <= 1'b0;
    end else begin
      edge_cnt <= (edge_cnt == 8'(EDGE_DIV - 1)) ? 8'h00 : edge_cnt + 8'h01;
      osc_edge <= (edge_cnt == 8'(EDGE_DIV - 1));
    end
  end
endmodule

//--- verification/rfc_top_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "rfc_map.svh"
`define CHK(nm, exp, act) \
  begin \
    checks++; \
    if ((act) !== (exp)) begin \
      errors++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, act); \
    end \
  end
module rfc_top_test;
  logic        ref_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [15:0] reg_addr  = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata;
  logic        int_osc_tick, low_osc_tick, high_osc_tick, osc_edge;
  logic        ref_osc_run, sen_a_osc_run, sen_b_osc_run;
  logic        free_running_osc_en, event_count_mode_en, channel_sel, irq;
  logic [1:0]  sensor_type_sel;
  int          errors = 0;
  int          checks = 0;

  always #20 ref_clk = ~ref_clk;

  rfc_top rfc_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .int_osc_tick(int_osc_tick), .low_osc_tick(low_osc_tick),
    .high_osc_tick(high_osc_tick), .osc_edge(osc_edge), .ref_osc_run(ref_osc_run),
    .sen_a_osc_run(sen_a_osc_run), .sen_b_osc_run(sen_b_osc_run),
    .free_running_osc_en(free_running_osc_en), .event_count_mode_en(event_count_mode_en),
    .sensor_type_sel(sensor_type_sel), .channel_sel(channel_sel), .irq(irq));

  rfc_osc_model rfc_osc_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .run_any(ref_osc_run | sen_a_osc_run | sen_b_osc_run), .int_osc_tick(int_osc_tick),
    .low_osc_tick(low_osc_tick), .high_osc_tick(high_osc_tick), .osc_edge(osc_edge));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled there
  task automatic rdchk(input logic [15:0] a, input logic [15:0] e, input string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask

  task automatic wait_idle(output int cyc);
    cyc = 0;
    #1;
    while ((ref_osc_run | sen_a_osc_run | sen_b_osc_run) !== 1'b0 && cyc < 2000) begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end
    if (cyc >= 2000) begin
      errors++;
      $display("CHECK FAILED run end expected 0 seen 1");
      results();
    end
  endtask

  // Start a run, wait for its end, then walk the flag through mask and clear
  task automatic run(input logic [15:0] trig, input logic [15:0] flg, output int cyc);
    wr(`RFC_ADR_TRG, trig);
    wait_idle(cyc);
    rdchk(`RFC_ADR_TRG, 16'h0000, "trigger after run");
    rdchk(`RFC_ADR_IFLG, flg, "flags after run");
    wr(`RFC_ADR_IMSK, flg ^ 16'h001f);
    #1;
    `CHK("irq other masks", 1'b0, irq)
    wr(`RFC_ADR_IMSK, flg);
    #1;
    `CHK("irq enabled", 1'b1, irq)
    wr(`RFC_ADR_IFLG, 16'h0000);
    rdchk(`RFC_ADR_IFLG, flg, "flags kept");
    wr(`RFC_ADR_IFLG, flg);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    rdchk(`RFC_ADR_IFLG, 16'h0000, "flags cleared");
    wr(`RFC_ADR_IMSK, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int          cyc;
    logic [15:0] adr [9];
    logic [15:0] rst [9];
    logic [15:0] wv  [9];
    logic [15:0] rb  [9];
    adr = '{`RFC_ADR_CLK, `RFC_ADR_CTL, `RFC_ADR_MCL, `RFC_ADR_MCH, `RFC_ADR_TCL,
            `RFC_ADR_TCH, `RFC_ADR_IMSK, `RFC_ADR_IFLG, 16'h53b0};
    rst = '{16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'h0000, 16'h0000};
    wv  = '{16'h00f9, 16'hffef, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
            16'hffff, 16'hffff};
    rb  = '{16'h0039, 16'h00e3, 16'hffff, 16'h00ff, 16'hffff, 16'h00ff, 16'h001f,
            16'h0000, 16'h0000};
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    `CHK("irq at reset", 1'b0, irq)
    for (int i = 0; i < 9; i++) rdchk(adr[i], rst[i], "reset value");
    rdchk(`RFC_ADR_TRG, 16'h0000, "trigger reset");
    for (int i = 0; i < 9; i++) wr(adr[i], wv[i]);
    for (int i = 0; i < 9; i++) rdchk(adr[i], rb[i], "readback");
    `CHK("control outputs", 5'h1d, {free_running_osc_en, event_count_mode_en,
         sensor_type_sel, channel_sel})
    for (int k = 0; k < 3; k++) begin
      wr(`RFC_ADR_CTL, 16'(k << 4));
      #1;
      `CHK("sensor type", 5'(k << 1), {free_running_osc_en, event_count_mode_en,
           sensor_type_sel, channel_sel})
    end
    $display("test registers done");
    wr(`RFC_ADR_IMSK, 16'h0000);
    wr(`RFC_ADR_TRG, 16'h0001);
    rdchk(`RFC_ADR_TRG, 16'h0000, "trigger while disabled");
    wr(`RFC_ADR_CTL, 16'h0001);
    wr(`RFC_ADR_CLK, 16'h0004);
    for (int i = 0; i < 3; i++) begin
      wr(`RFC_ADR_TRG, 16'(1 << i));
      rdchk(`RFC_ADR_TRG, 16'(1 << i), "trigger running");
      `CHK("run outputs", 3'(1 << i), {sen_b_osc_run, sen_a_osc_run, ref_osc_run})
      wr(`RFC_ADR_TRG, 16'h0000);
      rdchk(`RFC_ADR_TRG, 16'h0000, "trigger stopped");
      `CHK("run stopped", 3'h0, {sen_b_osc_run, sen_a_osc_run, ref_osc_run})
    end
    $display("test start stop done");
    // The preset counter wraps during the short reference run above; drop that flag
    wr(`RFC_ADR_IFLG, 16'h001f);
    wr(`RFC_ADR_MCL, 16'hfffd);
    wr(`RFC_ADR_MCH, 16'h00ff);
    run(16'h0001, 16'h0001, cyc);
    wr(`RFC_ADR_MCL, 16'h0000);
    wr(`RFC_ADR_MCH, 16'h0000);
    wr(`RFC_ADR_TCL, 16'hffff);
    wr(`RFC_ADR_TCH, 16'h00ff);
    wr(`RFC_ADR_CLK, 16'h0001);
    run(16'h0001, 16'h0010, cyc);
    wr(`RFC_ADR_CLK, 16'h0004);
    wr(`RFC_ADR_MCL, 16'hffff);
    wr(`RFC_ADR_MCH, 16'h00ff);
    run(16'h0002, 16'h0008, cyc);
    $display("test overflow done");
    wr(`RFC_ADR_TCL, 16'h0004);
    wr(`RFC_ADR_TCH, 16'h0000);
    wr(`RFC_ADR_CLK, 16'h0035);
    run(16'h0002, 16'h0002, cyc);
    `CHK("slow source undivided", 1'b1, (cyc >= 12 && cyc <= 42))
    rdchk(`RFC_ADR_TCL, 16'h0000, "time base at end");
    wr(`RFC_ADR_TCL, 16'h0002);
    wr(`RFC_ADR_CLK, 16'h0031);
    run(16'h0004, 16'h0004, cyc);
    `CHK("internal source by 8", 1'b1, (cyc >= 12 && cyc <= 42))
    $display("test completion done");
    wr(`RFC_ADR_CTL, 16'h0081);
    wr(`RFC_ADR_CLK, 16'h0001);
    wr(`RFC_ADR_MCL, 16'hfffe);
    wr(`RFC_ADR_MCH, 16'h00ff);
    wr(`RFC_ADR_TRG, 16'h0001);
    repeat (12) @(posedge ref_clk);
    rdchk(`RFC_ADR_TRG, 16'h0001, "continuous run");
    rdchk(`RFC_ADR_IFLG, 16'h0000, "continuous no completion");
    wr(`RFC_ADR_TRG, 16'h0000);
    wr(`RFC_ADR_CTL, 16'h0041);
    wr(`RFC_ADR_TCL, 16'h0005);
    wr(`RFC_ADR_TRG, 16'h0002);
    repeat (12) @(posedge ref_clk);
    rdchk(`RFC_ADR_TRG, 16'h0002, "event mode still running");
    rdchk(`RFC_ADR_TCL, 16'h0005, "event mode time base");
    wr(`RFC_ADR_TRG, 16'h0000);
    $display("test modes done");
    results();
  end
endmodule
